// file: inc/acqseq_pkg.sv
// Constants, types and helpers shared by the acquisition trigger sequencer
package acqseq_pkg;

  // ==========================================================
  // Widths and timing
  localparam int          DW            = 32;
  localparam int          AW            = 8;
  localparam int          SW            = 16;
  localparam int          CW            = 16;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          HOLDOFF_RST_NS = 0;
  localparam int          DELAY_RST_NS  = 0;
  localparam logic [31:0] HOLDOFF_RST   = 32'(HOLDOFF_RST_NS / CLK_PERIOD_NS);
  localparam logic [31:0] DELAY_RST     = 32'(DELAY_RST_NS / CLK_PERIOD_NS);

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_MIN_LEN = 8'h08;
  localparam logic [7:0] OFS_REC_LEN = 8'h0c;
  localparam logic [7:0] OFS_REF_POS = 8'h10;
  localparam logic [7:0] OFS_NUM_REC = 8'h14;
  localparam logic [7:0] OFS_LEVEL   = 8'h18;
  localparam logic [7:0] OFS_HYST    = 8'h1c;
  localparam logic [7:0] OFS_HOLDOFF = 8'h20;
  localparam logic [7:0] OFS_DELAY   = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;

  // ==========================================================
  // Field positions
  localparam int CTRL_INIT    = 0;
  localparam int CTRL_ABORT   = 1;
  localparam int CTRL_CLR_DON = 2;
  localparam int CTRL_CLR_ERR = 3;
  localparam int CFG_TYPE     = 0;
  localparam int CFG_SLOPE    = 2;
  localparam int CFG_START    = 3;
  localparam int CFG_ADV      = 4;
  localparam int CFG_RT       = 5;
  localparam int CFG_ETS      = 6;
  localparam int CFG_BITS     = 7;

  // ==========================================================
  // Reset values and limits
  localparam logic [6:0]  CFG_RST     = 7'h20;
  localparam logic [15:0] MIN_REC_LEN = 16'h0002;
  localparam logic [15:0] REC_LEN_RST = 16'h0100;
  localparam logic [6:0]  REF_POS_RST = 7'h32;
  localparam logic [6:0]  PCT_FULL    = 7'h64;
  localparam logic [15:0] NUM_REC_RST = 16'h0001;

  typedef enum logic [1:0] {TRIG_IMMEDIATE, TRIG_DIGITAL, TRIG_EDGE, TRIG_HYST} acqseq_trig_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_START, ST_PRE, ST_WAIT_REF, ST_DELAY, ST_POST, ST_WAIT_ADV
  } acqseq_state_t;

  // Edge of the selected direction; slope high means falling
  function automatic logic acqseq_edge(input logic prev, input logic cur, input logic slope);
    acqseq_edge = slope ? (prev & ~cur) : (~prev & cur);
  endfunction

endpackage

// file: inc/acqseq_trig_if.sv
// Configuration, sample and hit signals between sequencer and trigger detector
interface acqseq_trig_if;
  acqseq_pkg::acqseq_trig_t mode;
  logic                     slope;
  logic signed [15:0]       level;
  logic signed [15:0]       hyst;
  logic signed [15:0]       sample;
  logic                     dig;
  logic                     enable;
  logic                     hit;

  modport det (input mode, input slope, input level, input hyst, input sample,
               input dig, input enable, output hit);
  modport seq (output mode, output slope, output level, output hyst, output sample,
               output dig, output enable, input hit);
endinterface

// file: rtl/acqseq_countdown.sv
// Down-counter for holdoff and trigger delay, in clock cycles
module acqseq_countdown (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [31:0] value,
  output logic             busy
);
  logic [31:0] count;

  assign busy = (count != 32'h0);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count <= 32'h0;
    else if (ce)
      count <= load ? value : (busy ? count - 32'h1 : count);
  end
endmodule

// file: rtl/acqseq_top.sv
// Acquisition trigger sequencer: register port, record sequencing, trigger gating
// Operation
// (RL1) After initiate, store nothing until the start trigger arrives.
// (RL2) Start trigger is immediate when no external source is selected.
// (RL3) Start trigger begins storing pretrigger samples into the record.
// (RL4) Reference trigger is ignored until all pretrigger samples are stored.
// (RL5) After reference trigger, store posttrigger samples, then finish the record.
// (RL6) Records after the first start on the advance trigger, default immediate.
// (RL7) Acquire exactly the configured number of records, each fully sequenced.
// (RL8) Pre/post split follows reference position percent, default fifty.
// (RL9) Software asks at least two samples; reads back enlarged actual length.
// (RL10) After a trigger, further triggers ignored during holdoff, default zero.
// (RL11) Accepted trigger acts only after the trigger delay, default zero.
// (RL12) Digital and edge triggers use selected slope, rising by default.
// (RL13) Analog edge fires when sample crosses level in chosen direction.
// (RL14) Hysteresis fires after passing opposite bound, then crossing level.
// (RL15) Digital trigger configuration is refused while equivalent-time sampling is on.
// (RL16) Enforce-realtime, default true, forbids equivalent-time sampling.
// (RL17) Immediate reference trigger is generated internally.
// (RL18) Holdoff and delay are cycle down-counters gating acceptance and acquisition.
module acqseq_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] sample_in,
  input  wire logic        dig_trig_in,
  input  wire logic        start_trig_in,
  input  wire logic        adv_trig_in,
  output logic             store_en,
  output logic      [15:0] store_addr,
  output logic      [15:0] store_data,
  output logic      [15:0] record_index,
  output logic             ref_trig_seen,
  output logic             acq_busy,
  output logic             acq_done
);
  // ==========================================================
  // Configuration registers
  logic [6:0]               cfg;
  logic [15:0]              rec_len;
  logic [6:0]               ref_pos;
  logic [15:0]              num_rec;
  logic [15:0]              level;
  logic [15:0]              hyst;
  logic [31:0]              holdoff_cfg;
  logic [31:0]              delay_cfg;
  logic                     err_flag;
  logic [15:0]              pre_len;
  logic [15:0]              post_len;
  logic [15:0]              num_lat;
  logic [15:0]              cnt;
  logic                     prev_start;
  logic                     prev_adv;
  acqseq_pkg::acqseq_state_t state;
  acqseq_pkg::acqseq_state_t next_state;

  wire wr_ctrl = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_CTRL);
  wire wr_cfg  = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_CFG);
  wire wr_min  = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_MIN_LEN);
  wire wr_pos  = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_REF_POS);
  wire wr_num  = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_NUM_REC);
  wire wr_lvl  = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_LEVEL);
  wire wr_hys  = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_HYST);
  wire wr_hold = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_HOLDOFF);
  wire wr_dly  = ce & reg_wr & (reg_addr == acqseq_pkg::OFS_DELAY);

  wire initiate = wr_ctrl & reg_wdata[acqseq_pkg::CTRL_INIT] & (state == acqseq_pkg::ST_IDLE);
  wire abort    = wr_ctrl & reg_wdata[acqseq_pkg::CTRL_ABORT];
  wire clr_done = wr_ctrl & reg_wdata[acqseq_pkg::CTRL_CLR_DON];
  wire clr_err  = wr_ctrl & reg_wdata[acqseq_pkg::CTRL_CLR_ERR];

  // (RL16) equivalent-time only when realtime not enforced
  wire ets_active = cfg[acqseq_pkg::CFG_ETS] & ~cfg[acqseq_pkg::CFG_RT];
  wire wd_ets     = reg_wdata[acqseq_pkg::CFG_ETS] & ~reg_wdata[acqseq_pkg::CFG_RT];
  wire wd_dig     = reg_wdata[acqseq_pkg::CFG_TYPE +: 2] == acqseq_pkg::TRIG_DIGITAL;
  // (RL15) refuse digital type with equivalent-time
  wire cfg_reject = wr_cfg & wd_ets & wd_dig;

  // (RL9) enlarge short requests to the minimum
  wire [15:0] wd_len  = (reg_wdata[15:0] < acqseq_pkg::MIN_REC_LEN) ?
                        acqseq_pkg::MIN_REC_LEN : reg_wdata[15:0];
  wire [6:0]  wd_pos  = (reg_wdata[31:7] != 25'h0 || reg_wdata[6:0] > acqseq_pkg::PCT_FULL) ?
                        acqseq_pkg::PCT_FULL : reg_wdata[6:0];
  wire [15:0] wd_num  = (reg_wdata[15:0] == 16'h0) ? 16'h0001 : reg_wdata[15:0];

  // (RL8) pretrigger share from reference percent
  wire [22:0] pre_prod = 23'(rec_len) * 23'(ref_pos);
  wire [22:0] pre_div  = pre_prod / 23'(acqseq_pkg::PCT_FULL);
  wire [15:0] pre_calc = pre_div[15:0];

  // ==========================================================
  // Trigger detection, holdoff and delay
  acqseq_trig_if tif ();
  logic hold_busy;
  logic dly_busy;

  assign tif.mode   = acqseq_pkg::acqseq_trig_t'(cfg[acqseq_pkg::CFG_TYPE +: 2]);
  assign tif.slope  = cfg[acqseq_pkg::CFG_SLOPE];
  assign tif.level  = level;
  assign tif.hyst   = hyst;
  assign tif.sample = sample_in;
  assign tif.dig    = dig_trig_in;
  // (RL4) detector only looks once pretrigger is full
  assign tif.enable = (state == acqseq_pkg::ST_WAIT_REF);

  acqseq_trig_detect u_det (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .tif    (tif)
  );

  // (RL10) detection starts holdoff; hits ignored while running
  wire hold_load  = tif.hit & ~hold_busy;
  wire ref_accept = hold_load & (state == acqseq_pkg::ST_WAIT_REF);
  // (RL11) nonzero delay loads delay counter
  wire dly_load   = ref_accept & (delay_cfg != 32'h0);

  // (RL18) holdoff counter
  acqseq_countdown u_hold (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .load   (hold_load),
    .value  (holdoff_cfg),
    .busy   (hold_busy)
  );

  // (RL18) delay counter
  acqseq_countdown u_dly (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .load   (dly_load),
    .value  (delay_cfg - 32'h1),
    .busy   (dly_busy)
  );

  // (RL2) immediate start unless external source chosen
  wire start_fire = ~cfg[acqseq_pkg::CFG_START] |
                    acqseq_pkg::acqseq_edge(prev_start, start_trig_in, 1'b0);
  // (RL6) advance trigger, immediate by default
  wire adv_fire   = ~cfg[acqseq_pkg::CFG_ADV] |
                    acqseq_pkg::acqseq_edge(prev_adv, adv_trig_in, 1'b0);

  wire pre_full  = (cnt == pre_len);
  wire post_full = (cnt == post_len);
  wire last_rec  = (record_index == num_lat - 16'h1);
  wire rec_end   = (state == acqseq_pkg::ST_POST) & post_full;
  wire acq_end   = rec_end & last_rec;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      acqseq_pkg::ST_IDLE:
        if (initiate)
          next_state = acqseq_pkg::ST_WAIT_START;
      // (RL1) idle until start trigger
      acqseq_pkg::ST_WAIT_START:
        if (start_fire)
          next_state = acqseq_pkg::ST_PRE;
      acqseq_pkg::ST_PRE:
        if (pre_full)
          next_state = acqseq_pkg::ST_WAIT_REF;
      acqseq_pkg::ST_WAIT_REF:
        if (dly_load)
          next_state = acqseq_pkg::ST_DELAY;
        else if (ref_accept)
          next_state = acqseq_pkg::ST_POST;
      acqseq_pkg::ST_DELAY:
        if (!dly_busy)
          next_state = acqseq_pkg::ST_POST;
      // (RL5) finish after posttrigger count; (RL7) stop at last record
      acqseq_pkg::ST_POST:
        if (post_full)
          next_state = last_rec ? acqseq_pkg::ST_IDLE : acqseq_pkg::ST_WAIT_ADV;
      acqseq_pkg::ST_WAIT_ADV:
        if (adv_fire)
          next_state = acqseq_pkg::ST_PRE;
      default:
        next_state = acqseq_pkg::ST_IDLE;
    endcase
    if (abort)
      next_state = acqseq_pkg::ST_IDLE;
  end

  // (RL3) store pretrigger then posttrigger samples
  wire        next_store = ~abort & (((state == acqseq_pkg::ST_PRE) & ~pre_full) |
                                     ((state == acqseq_pkg::ST_POST) & ~post_full));
  wire [15:0] next_addr  = (state == acqseq_pkg::ST_POST) ? pre_len + cnt : cnt;
  wire        phase_chg  = (next_state != state);
  wire [15:0] next_cnt   = phase_chg ? 16'h0 : (next_store ? cnt + 16'h1 : cnt);
  wire [15:0] next_index = initiate ? 16'h0 : (rec_end & ~last_rec ? record_index + 16'h1 :
                                               record_index);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state        <= acqseq_pkg::ST_IDLE;
      cnt          <= 16'h0;
      record_index <= 16'h0;
      prev_start   <= 1'b0;
      prev_adv     <= 1'b0;
    end
    else if (ce)
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      record_index <= next_index;
      prev_start   <= start_trig_in;
      prev_adv     <= adv_trig_in;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      store_en      <= 1'b0;
      store_addr    <= 16'h0;
      store_data    <= 16'h0;
      ref_trig_seen <= 1'b0;
      acq_busy      <= 1'b0;
    end
    else if (ce)
    begin
      store_en      <= next_store;
      store_addr    <= next_addr;
      store_data    <= sample_in;
      ref_trig_seen <= ref_accept;
      acq_busy      <= (next_state != acqseq_pkg::ST_IDLE);
    end
  end

  // Latch record split and count at initiate
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_len  <= 16'h0;
      post_len <= 16'h0;
      num_lat  <= acqseq_pkg::NUM_REC_RST;
    end
    else if (initiate)
    begin
      pre_len  <= pre_calc;
      post_len <= rec_len - pre_calc;
      num_lat  <= num_rec;
    end
  end

  // ==========================================================
  // Register file; hardware set wins over software clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg         <= acqseq_pkg::CFG_RST;
      rec_len     <= acqseq_pkg::REC_LEN_RST;
      ref_pos     <= acqseq_pkg::REF_POS_RST;
      num_rec     <= acqseq_pkg::NUM_REC_RST;
      level       <= 16'h0;
      hyst        <= 16'h0;
      holdoff_cfg <= acqseq_pkg::HOLDOFF_RST;
      delay_cfg   <= acqseq_pkg::DELAY_RST;
      err_flag    <= 1'b0;
      acq_done    <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_cfg && !cfg_reject)
        cfg <= reg_wdata[acqseq_pkg::CFG_BITS-1:0];
      if (wr_min)
        rec_len <= wd_len;
      if (wr_pos)
        ref_pos <= wd_pos;
      if (wr_num)
        num_rec <= wd_num;
      if (wr_lvl)
        level <= reg_wdata[15:0];
      if (wr_hys)
        hyst <= reg_wdata[15:0];
      if (wr_hold)
        holdoff_cfg <= reg_wdata;
      if (wr_dly)
        delay_cfg <= reg_wdata;
      err_flag <= cfg_reject | (err_flag & ~clr_err);
      acq_done <= (acq_end & ~abort) | (acq_done & ~clr_done & ~initiate);
    end
  end

  wire [31:0] status_word = {8'h0, record_index, err_flag, ets_active, acq_done,
                             acq_busy, 1'b0, state};
  wire [31:0] rd_mux =
    (reg_addr == acqseq_pkg::OFS_CFG)     ? {25'h0, cfg} :
    (reg_addr == acqseq_pkg::OFS_MIN_LEN) ? {16'h0, rec_len} :
    (reg_addr == acqseq_pkg::OFS_REC_LEN) ? {16'h0, rec_len} :
    (reg_addr == acqseq_pkg::OFS_REF_POS) ? {25'h0, ref_pos} :
    (reg_addr == acqseq_pkg::OFS_NUM_REC) ? {16'h0, num_rec} :
    (reg_addr == acqseq_pkg::OFS_LEVEL)   ? {16'h0, level} :
    (reg_addr == acqseq_pkg::OFS_HYST)    ? {16'h0, hyst} :
    (reg_addr == acqseq_pkg::OFS_HOLDOFF) ? holdoff_cfg :
    (reg_addr == acqseq_pkg::OFS_DELAY)   ? delay_cfg :
    (reg_addr == acqseq_pkg::OFS_STATUS)  ? status_word : 32'h0;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0;
    else if (ce)
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_wait_no_store: assert property (ce && state == acqseq_pkg::ST_WAIT_START |=> !store_en) // (RL1)
    else $error("sample stored before start trigger");
  a_start_immed: assert property (ce && !abort && state == acqseq_pkg::ST_WAIT_START
                                  && !cfg[acqseq_pkg::CFG_START] |=> state == acqseq_pkg::ST_PRE) // (RL2)
    else $error("immediate start did not begin pretrigger");
  a_pre_stores: assert property (ce && !abort && state == acqseq_pkg::ST_PRE && !pre_full
                                 |=> store_en && store_addr == $past(cnt)) // (RL3)
    else $error("pretrigger sample not stored");
  a_ref_gated: assert property (ce && (state == acqseq_pkg::ST_PRE
                                || state == acqseq_pkg::ST_WAIT_START) |=> !ref_trig_seen) // (RL4)
    else $error("reference accepted before pretrigger full");
  a_post_done: assert property (ce && !abort && rec_end |=> state == acqseq_pkg::ST_IDLE
                                || state == acqseq_pkg::ST_WAIT_ADV) // (RL5)
    else $error("record not finished after posttrigger count");
  a_adv_immed: assert property (ce && !abort && state == acqseq_pkg::ST_WAIT_ADV
                                && !cfg[acqseq_pkg::CFG_ADV] |=> state == acqseq_pkg::ST_PRE) // (RL6)
    else $error("immediate advance did not start record");
  a_rec_count: assert property (ce && !abort && acq_end |=> acq_done && !acq_busy
                                && record_index == num_lat - 16'h1) // (RL7)
    else $error("acquisition ended with wrong record count");
  a_split_bound: assert property (store_en |-> store_addr < pre_len + post_len) // (RL8)
    else $error("stored sample outside record");
  a_len_min: assert property (rec_len >= acqseq_pkg::MIN_REC_LEN) // (RL9)
    else $error("record length below minimum");
  a_holdoff_blk: assert property (ce && hold_busy |=> !ref_trig_seen) // (RL10)
    else $error("trigger accepted during holdoff");
  a_delay_wait: assert property (ce && !abort && dly_load |=> state == acqseq_pkg::ST_DELAY
                                 && !store_en) // (RL11)
    else $error("delay not applied after trigger");
  a_dig_ets: assert property (tif.mode == acqseq_pkg::TRIG_DIGITAL |-> !ets_active) // (RL15)
    else $error("digital trigger with equivalent-time sampling");

  c_two_records: cover property (acq_end && num_lat == 16'h0002);
  c_delay_used: cover property (state == acqseq_pkg::ST_DELAY);
  c_cfg_reject: cover property (cfg_reject);
endmodule

// file: rtl/acqseq_trig_detect.sv
// Reference trigger detector: immediate, digital edge, analog edge, hysteresis
module acqseq_trig_detect (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   ce,
  acqseq_trig_if.det  tif
);
  logic signed [15:0] prev_sample;
  logic               prev_dig;
  logic               hyst_armed;
  logic               hit;

  wire signed [16:0] lvl   = 17'(tif.level);
  wire signed [16:0] cur   = 17'(tif.sample);
  wire signed [16:0] prv   = 17'(prev_sample);
  wire signed [16:0] lo_bd = lvl - 17'(tif.hyst);
  wire signed [16:0] hi_bd = lvl + 17'(tif.hyst);

  // (RL13) level crossing in chosen direction
  wire rise_x = (prv < lvl) && (cur >= lvl);
  wire fall_x = (prv >= lvl) && (cur < lvl);
  wire edge_x = tif.slope ? fall_x : rise_x;
  // (RL14) arm beyond opposite bound first
  wire arm_x  = tif.slope ? (cur > hi_bd) : (cur < lo_bd);
  wire hys_x  = hyst_armed & edge_x;
  // (RL12) digital edge of chosen slope
  wire dig_x  = acqseq_pkg::acqseq_edge(prev_dig, tif.dig, tif.slope);

  // (RL17) immediate fires without any event
  wire raw_hit = (tif.mode == acqseq_pkg::TRIG_IMMEDIATE) ? 1'b1 :
                 (tif.mode == acqseq_pkg::TRIG_DIGITAL)   ? dig_x :
                 (tif.mode == acqseq_pkg::TRIG_EDGE)      ? edge_x : hys_x;

  wire next_armed = arm_x ? 1'b1 : (hys_x ? 1'b0 : hyst_armed);

  assign tif.hit = hit;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_sample <= 16'sh0;
      prev_dig    <= 1'b0;
      hyst_armed  <= 1'b0;
      hit         <= 1'b0;
    end
    else if (ce)
    begin
      prev_sample <= tif.sample;
      prev_dig    <= tif.dig;
      hyst_armed  <= next_armed;
      hit         <= tif.enable & raw_hit;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_hyst_needs_arm: assert property (ce && tif.mode == acqseq_pkg::TRIG_HYST && tif.enable
                                     && !hyst_armed |=> !hit) // (RL14)
    else $error("hysteresis hit without prior arming");
  a_edge_dir: assert property (ce && tif.mode == acqseq_pkg::TRIG_EDGE && tif.enable
                               && !edge_x |=> !hit) // (RL13)
    else $error("edge hit without level crossing");
  c_hyst_hit: cover property (tif.mode == acqseq_pkg::TRIG_HYST && hit);
endmodule

// file: testbench/acqseq_host_model.sv
// Host register master model for the acquisition sequencer
module acqseq_host_model (
  input  wire logic        clk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One-cycle read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask
endmodule

// file: testbench/test_acqseq_top.sv
// Self-checking bench for the acquisition trigger sequencer
module test_acqseq_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, ce, reg_wr, reg_rd, start_trig_in;
  logic        dig_trig_in = 1'b0;
  logic        adv_trig_in = 1'b0;
  logic        rd_d        = 1'b0;
  logic        store_en, ref_trig_seen, acq_busy, acq_done;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [31:0] lfsr        = 32'h9c7c;
  logic [15:0] store_addr, store_data, record_index;
  logic [15:0] sample_in   = 16'h0;
  logic [15:0] smp_d       = 16'h0;
  int          fail_count, check_count, refs;
  logic [31:0] rd_q[$], st_q[$];

  acqseq_top i_acqseq_top (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_in(sample_in), .dig_trig_in(dig_trig_in), .start_trig_in(start_trig_in),
    .adv_trig_in(adv_trig_in), .store_en(store_en), .store_addr(store_addr),
    .store_data(store_data), .record_index(record_index), .ref_trig_seen(ref_trig_seen),
    .acq_busy(acq_busy), .acq_done(acq_done));
  acqseq_host_model i_acqseq_host_model (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_acqseq_host_model.wr(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    i_acqseq_host_model.rd(a);
  endtask
  // Two records of four samples, then wait for completion
  task automatic run(input logic [6:0] cfg, input int pos, input int hold, input int dly);
    int n;
    wr(acqseq_pkg::OFS_CFG, 32'(cfg));
    wr(acqseq_pkg::OFS_REF_POS, 32'(pos));
    wr(acqseq_pkg::OFS_HOLDOFF, 32'(hold));
    wr(acqseq_pkg::OFS_DELAY, 32'(dly));
    wr(acqseq_pkg::OFS_CTRL, 32'h4);
    for (int i = 0; i < 8; i++)
      st_q.push_back({16'(i / 4), 16'(i % 4)});
    refs = 0;
    wr(acqseq_pkg::OFS_CTRL, 32'h1);
    if (cfg[3])
    begin
      repeat (20) @(posedge clk);
      check(32'(st_q.size()), 32'h8);
      check(32'(acq_busy), 32'h1);
      start_trig_in <= 1'b1;
    end
    n = 0;
    while (acq_done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 3000)
    begin
      check(32'h0, 32'h1);
      print_verdict();
    end
    else
    begin
      start_trig_in <= 1'b0;
      check(32'(st_q.size()), 32'h0);
      check(32'(refs), 32'h2);
      check(32'(acq_busy), 32'h0);
    end
  endtask

  // ==========================================
  // Stimulus and monitor
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    lfsr        <= lfsr_next(lfsr);
    sample_in   <= lfsr[15:0];
    dig_trig_in <= lfsr[3];
    adv_trig_in <= lfsr[9];
    rd_d        <= reg_rd;
    smp_d       <= sample_in;
    if (rd_d)
      check(reg_rdata, rd_q.size() > 0 ? rd_q.pop_front() : 32'hdead_beef);
    if (store_en === 1'b1)
    begin
      check({record_index, store_addr},
            st_q.size() > 0 ? st_q.pop_front() : 32'hffff_ffff);
      check(32'(store_data), 32'(smp_d));
    end
    if (ref_trig_seen === 1'b1)
      refs++;
  end
  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    start_trig_in = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(acqseq_pkg::OFS_CFG, 32'h20);
    rd_chk(acqseq_pkg::OFS_REF_POS, 32'h32);
    rd_chk(acqseq_pkg::OFS_REC_LEN, 32'h100);
    rd_chk(acqseq_pkg::OFS_HOLDOFF, 32'h0);
    rd_chk(acqseq_pkg::OFS_DELAY, 32'h0);
    rd_chk(8'h3c, 32'h0);
    // Frozen port ignores the write
    ce <= 1'b0;
    wr(acqseq_pkg::OFS_LEVEL, 32'h1234);
    ce <= 1'b1;
    rd_chk(acqseq_pkg::OFS_LEVEL, 32'h0);
    wr(acqseq_pkg::OFS_MIN_LEN, 32'h3);
    rd_chk(acqseq_pkg::OFS_REC_LEN, 32'h3);
    wr(acqseq_pkg::OFS_MIN_LEN, 32'h4);
    wr(acqseq_pkg::OFS_NUM_REC, 32'h2);
    wr(acqseq_pkg::OFS_LEVEL, 32'h0);
    wr(acqseq_pkg::OFS_HYST, 32'h100);
    wr(acqseq_pkg::OFS_CFG, 32'h41);
    rd_chk(acqseq_pkg::OFS_CFG, 32'h20);
    rd_chk(acqseq_pkg::OFS_STATUS, 32'h80);
    for (int t = 0; t < 8; t++)
      run(7'h20 | 7'(t), t * 20, t, t % 2 * 3);
    run(7'h38, 50, 0, 0);
    // Abort while waiting for start, clear the error flag
    wr(acqseq_pkg::OFS_CTRL, 32'h1);
    rd_chk(acqseq_pkg::OFS_STATUS, 32'h91);
    wr(acqseq_pkg::OFS_CTRL, 32'ha);
    rd_chk(acqseq_pkg::OFS_STATUS, 32'h0);
    print_verdict();
  end
endmodule
